// ==== psd_params.svh ====
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// Clock and time base
`define PSD_CLK_HZ      25000000
`define PSD_TICK_MS     5
`define PSD_MS_CYC      (`PSD_CLK_HZ / 1000)
`define PSD_TICK_CYC    (`PSD_MS_CYC * `PSD_TICK_MS)

// APB byte offsets
`define PSD_A_CTRL      8'h00
`define PSD_A_STAT      8'h04
`define PSD_A_CLR       8'h08
`define PSD_A_CNT_S     8'h0c
`define PSD_A_CNT_T     8'h10
`define PSD_A_CNT_B     8'h14
`define PSD_A_LOG_LO    8'h18
`define PSD_A_LOG_HI    8'h1c
`define PSD_A_XOFF      8'h20
`define PSD_A_ROFF      8'h24
`define PSD_A_RAD       8'h28
`define PSD_A_BLP       8'h2c
`define PSD_A_BLN       8'h30
`define PSD_A_TRAV      8'h34
`define PSD_A_LIM       8'h38
`define PSD_A_RSTI      8'h3c
`define PSD_A_OPD       8'h40

// Control field positions
`define PSD_C_EN        0
`define PSD_C_FEN       1
`define PSD_C_FST       3:2
`define PSD_C_GSEL      6:4
`define PSD_C_LIDX      11:8

// Setting defaults, impedances in 0.01 ohm
`define PSD_DEF_XOFF    24'hffec78
`define PSD_DEF_ROFF    24'h000000
`define PSD_DEF_RAD     24'h001388
`define PSD_DEF_BLP     24'h0007d0
`define PSD_DEF_BLN     24'hfff830
`define PSD_DEF_LIM     3'h1
`define PSD_TRAV_MS     50
`define PSD_RSTI_MS     1000
`define PSD_DEF_TRAV    20'(`PSD_TRAV_MS / `PSD_TICK_MS)
`define PSD_DEF_RSTI    20'(`PSD_RSTI_MS / `PSD_TICK_MS)
`define PSD_DEF_OPD     20'h00000

// Log geometry
`define PSD_LOG_DEPTH   12

`endif

// ==== psd_pkg.sv ====
`default_nettype none
package psd_pkg;

  typedef enum logic [1:0] {
    PSD_OUT     = 2'h0,
    PSD_IN      = 2'h1,
    PSD_BAND    = 2'h3,
    PSD_CROSSED = 2'h2
  } psd_slip_e;

  typedef enum logic [1:0] {
    PSD_F_NORMAL  = 2'h0,
    PSD_F_START   = 2'h1,
    PSD_F_TRIP    = 2'h2,
    PSD_F_BLOCKED = 2'h3
  } psd_force_e;

  typedef struct packed {
    logic signed [23:0] xoff;
    logic signed [23:0] roff;
    logic signed [23:0] rad;
    logic signed [23:0] blp;
    logic signed [23:0] bln;
    logic [19:0]        trav;
    logic [2:0]         lim;
    logic [19:0]        rsti;
    logic [19:0]        opd;
  } psd_grp_s;

  typedef struct packed {
    logic [1:0] src;
    logic       on;
  } psd_evt_s;

  typedef struct packed {
    logic [31:0] ms;
    logic [1:0]  src;
    logic [2:0]  grp;
    logic [19:0] btime;
    logic [6:0]  rsvd;
  } psd_rec_s;

  typedef struct packed {
    logic [16:0]    tdiv;
    logic [15:0]    mdiv;
    logic [31:0]    ms;
    logic           en;
    logic           fen;
    psd_force_e     fst;
    logic [2:0]     gsel;
    logic [3:0]     lidx;
    psd_grp_s [7:0] set;
    logic           blk;
    psd_slip_e      st;
    logic           side;
    logic           fside;
    logic [19:0]    tmr;
    logic [19:0]    btime;
    logic [2:0]     slips;
    logic [19:0]    rtmr;
    logic [19:0]    optmr;
    logic           start;
    logic           trip;
    logic           blocked;
    logic           note;
    logic [15:0]    cnt_s;
    logic [15:0]    cnt_t;
    logic [15:0]    cnt_b;
    logic [5:0]     pend;
    logic [31:0]    stamp;
    logic [31:0]    imp;
    logic           evt_v;
    psd_evt_s       evt_id;
    logic [31:0]    evt_ms;
    logic [31:0]    evt_imp;
    logic [3:0]     lptr;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } psd_st_s;

  typedef struct packed {
    psd_rec_s [11:0] mem;
    psd_rec_s        rd;
  } psd_mem_s;

endpackage

`default_nettype wire

// ==== psd_log_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psd_params.svh"

module psd_log_mem (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              we,
  input  wire logic [3:0]        waddr,
  input  wire psd_pkg::psd_rec_s wdata,
  input  wire logic [3:0]        raddr,
  output var  psd_pkg::psd_rec_s rdata
);
  import psd_pkg::*;

  psd_mem_s s;
  psd_mem_s n;

  always_comb
  begin
    n = s;
    if (we && waddr < 4'(`PSD_LOG_DEPTH))
    begin
      n.mem[waddr] = wdata;
    end
    n.rd = (raddr < 4'(`PSD_LOG_DEPTH)) ? s.mem[raddr] : '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign rdata = s.rd;

endmodule // psd_log_mem

`default_nettype wire

// ==== psd_pole_slip.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psd_params.svh"

// Operation
// - Blocking input sampled once per processing tick, used for that tick.
// - Pick-up without blocking raises START and starts operate evaluation.
// - Pick-up under blocking raises BLOCKED instead, no operate evaluation.
// - Blocking arriving during START drops START as if pick-up ended.
// - Blocking activation raises a display pulse and impedance-stamped event.
// - Eight setting groups, active group chosen by setting_group, APB access by gsel.
// - START, TRIP, BLOCKED each give ON and OFF events, 1 ms stamp.
// - Blocking issues START OFF and BLOCKED ON events with identical stamp.
// - Separate clearable cumulative counters for START, TRIP, BLOCKED.
// - Impedance derived from phase currents and voltage, 5 ms RMS base.
// - Circle with X, R offsets and radius, plus two resistive blinders.
// - Slip needs circle entry, blinder crossing inside, then circle exit.
// - Slip counts only if band time exceeds minimum traverse setting.
// - Later slips count only when entering from the first slip's side.
// - Trip when counted slips reach the detection limit.
// - Slip counter clears after reset interval without a new slip.
// - Stage forcing lets software force status and the blocking input.
// - START only while blocking is inactive, never from pick-up alone.
// - Last twelve ON events recorded with stamp and process data.
module psd_pole_slip #(
  parameter int TICK_CYCLES = `PSD_TICK_CYC,
  parameter int MS_CYCLES   = `PSD_MS_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic [15:0]        phase1_current_rms,
  input  wire logic [15:0]        phase2_current_rms,
  input  wire logic [15:0]        phase3_current_rms,
  input  wire logic signed [15:0] volt_res,
  input  wire logic signed [15:0] volt_rea,
  input  wire logic [2:0]         setting_group,
  input  wire logic               block_in,
  output var  logic               start,
  output var  logic               trip,
  output var  logic               blocked,
  output var  logic               disp_note,
  output var  logic               evt_valid,
  output var  psd_pkg::psd_evt_s  evt_id,
  output var  logic [31:0]        evt_ms,
  output var  logic [31:0]        evt_imp
);
  import psd_pkg::*;

  localparam psd_grp_s GRP_DEF = '{
    xoff: `PSD_DEF_XOFF, roff: `PSD_DEF_ROFF, rad: `PSD_DEF_RAD,
    blp: `PSD_DEF_BLP, bln: `PSD_DEF_BLN, trav: `PSD_DEF_TRAV,
    lim: `PSD_DEF_LIM, rsti: `PSD_DEF_RSTI, opd: `PSD_DEF_OPD};

  psd_st_s            s;
  psd_st_s            n;
  psd_grp_s           g;
  psd_rec_s           rec_w;
  psd_rec_s           rec_r;
  logic               log_we;
  logic [17:0]        isum;
  logic signed [43:0] vr3;
  logic signed [43:0] vx3;
  logic signed [43:0] ir0;
  logic signed [43:0] ix0;
  logic signed [43:0] irad;
  logic signed [43:0] ibp;
  logic signed [43:0] ibn;
  logic signed [43:0] dr;
  logic signed [43:0] dx;
  logic signed [88:0] d2;
  logic signed [88:0] r2;
  logic               in_c;
  logic               right;
  logic               left;
  logic               band;
  logic               tick;
  logic               blk;
  logic               pick;
  logic               reach;
  logic               start_n;
  logic               trip_n;
  logic               blk_n;
  logic [2:0]         clr;
  logic [5:0]         ch;
  logic               found;

  assign g = s.set[setting_group];

  // Impedance test by cross-multiplying with the current sum, no divider
  assign isum = 18'(phase1_current_rms) + 18'(phase2_current_rms)
              + 18'(phase3_current_rms);
  assign vr3  = 44'($signed(volt_res) * 3);
  assign vx3  = 44'($signed(volt_rea) * 3);
  assign ir0  = 44'(g.roff * $signed({1'b0, isum}));
  assign ix0  = 44'(g.xoff * $signed({1'b0, isum}));
  assign irad = 44'(g.rad * $signed({1'b0, isum}));
  assign ibp  = 44'(g.blp * $signed({1'b0, isum}));
  assign ibn  = 44'(g.bln * $signed({1'b0, isum}));
  assign dr   = vr3 - ir0;
  assign dx   = vx3 - ix0;
  assign d2   = 89'(dr * dr) + 89'(dx * dx);
  assign r2   = 89'(irad * irad);
  assign in_c  = (isum != 18'h0) && (d2 < r2);
  assign right = (vr3 >= ibp);
  assign left  = (vr3 <= ibn);
  assign band  = !right && !left;

  assign log_we      = s.evt_v && s.evt_id.on;
  assign rec_w.ms    = s.evt_ms;
  assign rec_w.src   = s.evt_id.src;
  assign rec_w.grp   = setting_group;
  assign rec_w.btime = s.btime;
  assign rec_w.rsvd  = 7'h0;

  psd_log_mem u_log (
    .clk   (clk),
    .reset (reset),
    .we    (log_we),
    .waddr (s.lptr),
    .wdata (rec_w),
    .raddr (s.lidx),
    .rdata (rec_r)
  );

  always_comb
  begin
    n       = s;
    blk     = s.blk;
    pick    = 1'b0;
    reach   = 1'b0;
    start_n = s.start;
    trip_n  = s.trip;
    blk_n   = s.blocked;
    clr     = 3'h0;
    ch      = 6'h0;
    found   = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.evt_v   = 1'b0;
    n.note    = 1'b0;

    tick   = (s.tdiv == 17'h0);
    n.tdiv = tick ? 17'(TICK_CYCLES - 1) : s.tdiv - 17'h1;
    if (s.mdiv == 16'h0)
    begin
      n.mdiv = 16'(MS_CYCLES - 1);
      n.ms   = s.ms + 32'h1;
    end
    else
    begin
      n.mdiv = s.mdiv - 16'h1;
    end

    // APB access phase, answered one cycle after penable rises
    if (psel && penable && !s.pready)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (paddr)
        `PSD_A_CTRL:
        begin
          n.prdata = {20'h0, s.lidx, 1'b0, s.gsel, s.fst, s.fen, s.en};
          if (pwrite)
          begin
            n.en   = pwdata[`PSD_C_EN];
            n.fen  = pwdata[`PSD_C_FEN];
            n.fst  = psd_force_e'(pwdata[`PSD_C_FST]);
            n.gsel = pwdata[`PSD_C_GSEL];
            n.lidx = pwdata[`PSD_C_LIDX];
          end
        end
        `PSD_A_STAT:
          n.prdata = {17'h0, s.lptr, s.st, s.fside, s.side, s.slips,
                      s.blk, s.blocked, s.trip, s.start};
        `PSD_A_CLR:
          if (pwrite)
          begin
            clr = pwdata[2:0];
          end
        `PSD_A_CNT_S:  n.prdata = {16'h0, s.cnt_s};
        `PSD_A_CNT_T:  n.prdata = {16'h0, s.cnt_t};
        `PSD_A_CNT_B:  n.prdata = {16'h0, s.cnt_b};
        `PSD_A_LOG_LO: n.prdata = rec_r[31:0];
        `PSD_A_LOG_HI: n.prdata = rec_r[63:32];
        `PSD_A_XOFF:
        begin
          n.prdata = 32'(s.set[s.gsel].xoff);
          if (pwrite) n.set[s.gsel].xoff = pwdata[23:0];
        end
        `PSD_A_ROFF:
        begin
          n.prdata = 32'(s.set[s.gsel].roff);
          if (pwrite) n.set[s.gsel].roff = pwdata[23:0];
        end
        `PSD_A_RAD:
        begin
          n.prdata = 32'(s.set[s.gsel].rad);
          if (pwrite) n.set[s.gsel].rad = pwdata[23:0];
        end
        `PSD_A_BLP:
        begin
          n.prdata = 32'(s.set[s.gsel].blp);
          if (pwrite) n.set[s.gsel].blp = pwdata[23:0];
        end
        `PSD_A_BLN:
        begin
          n.prdata = 32'(s.set[s.gsel].bln);
          if (pwrite) n.set[s.gsel].bln = pwdata[23:0];
        end
        `PSD_A_TRAV:
        begin
          n.prdata = {12'h0, s.set[s.gsel].trav};
          if (pwrite) n.set[s.gsel].trav = pwdata[19:0];
        end
        `PSD_A_LIM:
        begin
          n.prdata = {29'h0, s.set[s.gsel].lim};
          if (pwrite) n.set[s.gsel].lim = pwdata[2:0];
        end
        `PSD_A_RSTI:
        begin
          n.prdata = {12'h0, s.set[s.gsel].rsti};
          if (pwrite) n.set[s.gsel].rsti = pwdata[19:0];
        end
        `PSD_A_OPD:
        begin
          n.prdata = {12'h0, s.set[s.gsel].opd};
          if (pwrite) n.set[s.gsel].opd = pwdata[19:0];
        end
        default:
          n.pslverr = 1'b1;
      endcase
    end

    // Clear first so that an edge in the same cycle still counts
    n.cnt_s = clr[0] ? 16'h0 : s.cnt_s;
    n.cnt_t = clr[1] ? 16'h0 : s.cnt_t;
    n.cnt_b = clr[2] ? 16'h0 : s.cnt_b;

    if (tick)
    begin
      // Forced blocking replaces the matrix input while forcing is on
      blk   = s.fen ? (s.fst == PSD_F_BLOCKED) : block_in;
      n.blk = blk;

      case (s.st)
        PSD_OUT:
          if (in_c)
          begin
            n.st   = PSD_IN;
            n.side = (vr3 >= ir0);
          end
        PSD_IN:
          if (!in_c)
          begin
            n.st = PSD_OUT;
          end
          else if (band)
          begin
            n.st  = PSD_BAND;
            n.tmr = 20'h1;
          end
        PSD_BAND:
          if (!in_c)
          begin
            n.st = PSD_OUT;
          end
          else if (band)
          begin
            n.tmr = (s.tmr == 20'hfffff) ? s.tmr : s.tmr + 20'h1;
          end
          else if ((right != s.side) && (s.tmr > g.trav))
          begin
            n.st    = PSD_CROSSED;
            n.btime = s.tmr;
          end
          else
          begin
            n.st = PSD_IN;
          end
        PSD_CROSSED:
          if (!in_c)
          begin
            n.st = PSD_OUT;
            if (s.slips == 3'h0 || s.side == s.fside)
            begin
              n.slips = (s.slips == 3'h7) ? s.slips : s.slips + 3'h1;
              n.rtmr  = 20'h0;
              if (s.slips == 3'h0)
              begin
                n.fside = s.side;
              end
            end
          end
        default:
          n.st = PSD_OUT;
      endcase

      if (s.slips != 3'h0 && n.slips == s.slips)
      begin
        if (s.rtmr >= g.rsti)
        begin
          n.slips = 3'h0;
          n.rtmr  = 20'h0;
        end
        else
        begin
          n.rtmr = s.rtmr + 20'h1;
        end
      end

      // Next slip count keeps START up through the tick that counts a slip
      pick = s.en && (in_c || n.slips != 3'h0);
      // Blocked pick-up skips the operate path entirely
      if (pick && !blk && s.slips >= g.lim && g.lim != 3'h0)
      begin
        if (s.optmr >= g.opd)
        begin
          reach = 1'b1;
        end
        else
        begin
          n.optmr = s.optmr + 20'h1;
        end
      end
      else
      begin
        n.optmr = 20'h0;
      end

      start_n = pick && !blk;
      trip_n  = pick && !blk && (s.trip || reach);
      blk_n   = pick && blk;
      if (s.fen)
      begin
        start_n = (s.fst == PSD_F_START);
        trip_n  = (s.fst == PSD_F_TRIP);
        blk_n   = (s.fst == PSD_F_BLOCKED);
      end

      // ON/OFF edges of the three outputs share one stamp per tick
      ch = {!blk_n && s.blocked, blk_n && !s.blocked,
            !trip_n && s.trip, trip_n && !s.trip,
            !start_n && s.start, start_n && !s.start};
      if (ch != 6'h0)
      begin
        n.pend  = s.pend | ch;
        n.stamp = s.ms;
        n.imp   = {volt_res, volt_rea};
      end
      n.note    = blk_n && !s.blocked;
      n.start   = start_n;
      n.trip    = trip_n;
      n.blocked = blk_n;
      if (ch[0]) n.cnt_s = n.cnt_s + 16'h1;
      if (ch[2]) n.cnt_t = n.cnt_t + 16'h1;
      if (ch[4]) n.cnt_b = n.cnt_b + 16'h1;
    end

    // Drain pending events, one per clock, lowest first
    for (int i = 0; i < 6; i++)
    begin
      if (!found && s.pend[i])
      begin
        found         = 1'b1;
        n.pend[i]     = ch[i];
        n.evt_v       = 1'b1;
        n.evt_id.src  = 2'(i / 2);
        n.evt_id.on   = (i % 2 == 0);
        n.evt_ms      = s.stamp;
        n.evt_imp     = s.imp;
      end
    end

    if (log_we)
    begin
      n.lptr = (s.lptr == 4'(`PSD_LOG_DEPTH - 1)) ? 4'h0 : s.lptr + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.en <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        s.set[i] <= GRP_DEF;
      end
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign start     = s.start;
  assign trip      = s.trip;
  assign blocked   = s.blocked;
  assign disp_note = s.note;
  assign evt_valid = s.evt_v;
  assign evt_id    = s.evt_id;
  assign evt_ms    = s.evt_ms;
  assign evt_imp   = s.evt_imp;

endmodule // psd_pole_slip

`default_nettype wire

// ==== psd_pole_slip_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module psd_pole_slip_checker #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              start,
  input wire logic              trip,
  input wire logic              blocked,
  input wire logic              disp_note,
  input wire logic              evt_valid,
  input wire psd_pkg::psd_evt_s evt_id,
  input wire logic [31:0]       evt_ms
);
  import psd_pkg::*;
  logic [19:0] tcnt_q;
  logic [19:0] tcnt_d;
  // Mirrors the processing tick, phase 0 at the first edge after reset
  always_comb
  begin
    tcnt_d = (tcnt_q == 20'(TICK_CYCLES - 1)) ? 20'h0 : tcnt_q + 20'h1;
  end
  always_ff @(posedge clk)
  begin
    tcnt_q <= reset ? 20'h0 : tcnt_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_start_free; start |-> !blocked; endproperty
  a_start_free: assert property (p_start_free)
    else $error("start high while blocked");
  property p_trip_free; trip |-> !blocked; endproperty
  a_trip_free: assert property (p_trip_free)
    else $error("trip high while blocked");
  property p_note_rise; $rose(blocked) |-> ##[0:1] disp_note; endproperty
  a_note_rise: assert property (p_note_rise)
    else $error("no display pulse on blocked rise");
  property p_note_cause; disp_note |-> ##[0:1] blocked; endproperty
  a_note_cause: assert property (p_note_cause)
    else $error("display pulse without blocked");
  property p_out_tick;
    (tcnt_q > 20'h3) |-> $stable(start) && $stable(trip) && $stable(blocked);
  endproperty
  a_out_tick: assert property (p_out_tick)
    else $error("stage output moved between ticks");
  property p_evt_same;
    evt_valid && $past(evt_valid) |-> evt_ms == $past(evt_ms);
  endproperty
  a_evt_same: assert property (p_evt_same)
    else $error("events of one tick carry different stamps");
  property p_start_evt;
    $rose(start) |-> ##[0:8] (evt_valid && evt_id.src == 2'h0 && evt_id.on);
  endproperty
  a_start_evt: assert property (p_start_evt)
    else $error("no start on event");
  property p_apb_wait;
    (psel && !penable) ##1 (psel && penable) |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not one cycle after access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
endmodule // psd_pole_slip_checker

bind psd_pole_slip psd_pole_slip_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .start(start), .trip(trip),
  .blocked(blocked), .disp_note(disp_note), .evt_valid(evt_valid),
  .evt_id(evt_id), .evt_ms(evt_ms)
);
`default_nettype wire

// ==== psd_meas_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psd_meas_model (
  input  wire logic [15:0] z_r,
  input  wire logic [15:0] z_x,
  input  wire logic        blk_req,
  output var  logic [15:0] i1,
  output var  logic [15:0] i2,
  output var  logic [15:0] i3,
  output var  logic [15:0] v_res,
  output var  logic [15:0] v_rea,
  output var  logic        block_out
);
  // Unit phase currents make the computed impedance equal the voltage words
  assign i1 = 16'h0001;
  assign i2 = 16'h0001;
  assign i3 = 16'h0001;
  assign v_res = z_r;
  assign v_rea = z_x;
  // Blocking follows the request directly, with no lead or delay
  assign block_out = blk_req;
endmodule // psd_meas_model
`default_nettype wire

// ==== psd_pole_slip_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end

module psd_pole_slip_test;
  import psd_pkg::*;
  localparam int TCK = 20;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        err;
  logic        blk_req = 1'b0;
  logic [2:0]  sg = 3'h0;
  logic [15:0] z_r = 16'h2328;
  logic [15:0] z_x = 16'h2328;
  wire logic [15:0] i1, i2, i3, v_res, v_rea;
  wire logic        block_in, pready, pslverr, start, trip, blocked;
  wire logic        disp_note, evt_valid;
  wire logic [31:0] prdata, evt_ms, evt_imp;
  psd_evt_s    evt_id;
  int          miscompares = 0;
  int          checks_done = 0;
  int          ev_n [8];
  logic [31:0] ev_ms [8];
  logic [31:0] ev_imp [8];
  logic [7:0]  da [9] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
                          8'h3c, 8'h40};
  logic [31:0] dv [9] = '{32'hffffec78, 32'h0, 32'h1388, 32'h7d0,
                          32'hfffff830, 32'ha, 32'h1, 32'hc8, 32'h0};

  initial
  begin
    forever #20 clk = ~clk;
  end

  psd_meas_model pm (.z_r(z_r), .z_x(z_x), .blk_req(blk_req), .i1(i1),
    .i2(i2), .i3(i3), .v_res(v_res), .v_rea(v_rea), .block_out(block_in));

  psd_pole_slip #(.TICK_CYCLES(TCK), .MS_CYCLES(4)) uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase1_current_rms(i1),
    .phase2_current_rms(i2), .phase3_current_rms(i3), .volt_res(v_res),
    .volt_rea(v_rea), .setting_group(sg), .block_in(block_in),
    .start(start), .trip(trip), .blocked(blocked), .disp_note(disp_note),
    .evt_valid(evt_valid), .evt_id(evt_id), .evt_ms(evt_ms),
    .evt_imp(evt_imp)
  );

  // Keeps count, stamp and impedance of the last event of each kind
  always @(posedge clk)
  begin
    if (evt_valid === 1'b1)
    begin
      ev_n[evt_id] <= ev_n[evt_id] + 1;
      ev_ms[evt_id] <= evt_ms;
      ev_imp[evt_id] <= evt_imp;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic wt(input int n);
    repeat (n * TCK) @(posedge clk);
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (da[i]) rd_chk(da[i], dv[i]);
    apb(1'b0, 8'h80, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h38, 32'h3);
    rd_chk(8'h38, 32'h3);
    apb(1'b1, 8'h00, 32'h1);
    rd_chk(8'h38, 32'h1);
    apb(1'b1, 8'h34, 32'h2);
    wt(2);
    `CHK(start, 1'b0)
    z_r <= 16'h0fa0;
    z_x <= 16'hec78;
    wt(2);
    `CHK(start, 1'b1)
    `CHK(ev_n[1], 1)
    rd_chk(8'h0c, 32'h1);
    z_r <= 16'h0000;
    wt(4);
    z_r <= 16'hf060;
    wt(2);
    `CHK(trip, 1'b0)
    z_r <= 16'he0c0;
    wt(3);
    `CHK(trip, 1'b1)
    `CHK(ev_n[3], 1)
    rd_chk(8'h10, 32'h1);
    blk_req <= 1'b1;
    wt(2);
    `CHK(start, 1'b0)
    `CHK(blocked, 1'b1)
    `CHK(ev_n[0], 1)
    `CHK(ev_n[5], 1)
    `CHK(ev_imp[5], {16'he0c0, 16'hec78})
    `CHK(ev_ms[5], ev_ms[0])
    rd_chk(8'h14, 32'h1);
    apb(1'b1, 8'h08, 32'h7);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h14, 32'h0);
    blk_req <= 1'b0;
    sg <= 3'h1;
    wt(2);
    `CHK(blocked, 1'b0)
    `CHK(ev_n[4], 1)
    `CHK(start, 1'b1)
    `CHK(trip, 1'b0)
    apb(1'b1, 8'h00, 32'h301);
    rd_chk(8'h18, 32'h08000200);
    apb(1'b1, 8'h00, 32'h101);
    rd_chk(8'h18, 32'h40000200);
    apb(1'b1, 8'h00, 32'hb);
    wt(2);
    `CHK(trip, 1'b1)
    `CHK(start, 1'b0)
    apb(1'b1, 8'h00, 32'hf);
    wt(2);
    `CHK(blocked, 1'b1)
    rd_chk(8'h04, 32'h319c);
    stop_test;
  end
endmodule // psd_pole_slip_test
`default_nettype wire
